//--- core/bmc_chan.sv
`timescale 1ns/1ps
`default_nettype none
module bmc_chan
  import bmc_pkg::*;
#(
  parameter bit HAS_EXTRA = 1'b0
) (
  input  wire logic [31:0] cond,
  input  wire logic        sel_flag,
  input  wire logic        cyc_valid,
  input  wire logic        cyc_fetch,
  input  wire logic        cyc_write,
  input  wire logic [2:0]  cyc_size,
  input  wire logic [1:0]  cyc_bus,
  input  wire logic [7:0]  cyc_asid,
  input  wire logic [63:0] cyc_data,
  input  wire logic        cyc_nodata,
  input  wire logic [31:0] data_val,
  input  wire logic [31:0] data_mask,
  output logic             hit
);
  logic [1:0] cyc_t;
  logic [1:0] dir_t;
  logic       oper_sel;
  logic       cyc_ok;
  logic       dir_ok;
  logic       size_ok;
  logic       bus_ok;
  logic       asid_ok;
  logic       flag_ok;
  logic       data_ok;
  logic       lo_ok;
  logic       hi_ok;
  logic       fsel_ok;

  always_comb begin
    cyc_t    = cond[BMC_CYC_HI:BMC_CYC_LO];
    dir_t    = cond[BMC_DIR_HI:BMC_DIR_LO];
    cyc_ok   = cyc_fetch ? (cyc_t != BMC_CYC_OPER) : (cyc_t != BMC_CYC_FETCH); // RQ10
    oper_sel = !cyc_fetch; // RQ8
    dir_ok   = !oper_sel || (dir_t == BMC_DIR_WRITE && cyc_write)
             || (dir_t == BMC_DIR_READ && !cyc_write)
             || (dir_t != BMC_DIR_READ && dir_t != BMC_DIR_WRITE); // RQ11
    size_ok  = !oper_sel || cond[BMC_SIZE_HI:BMC_SIZE_LO] == BMC_SZ_ANY
             || cond[BMC_SIZE_HI:BMC_SIZE_LO] == cyc_size; // RQ7
    bus_ok   = !oper_sel || (cond[BMC_BUS_HI:BMC_BUS_LO] == BMC_BUS_OPER
             && cyc_bus == BMC_BUS_OPER); // RQ9
    asid_ok  = !cond[BMC_ASID_EN]
             || cond[BMC_ASID_HI:BMC_ASID_LO] == cyc_asid; // RQ2
    fsel_ok  = cond[BMC_FSEL_HI:BMC_FSEL_LO] == BMC_FSEL_CH0
             || cond[BMC_FSEL_HI:BMC_FSEL_LO] == BMC_FSEL_CH1; // RQ3
    flag_ok  = !cond[BMC_FLAG_EN] || (fsel_ok && sel_flag); // RQ1 RQ5 RQ6
    lo_ok    = ((cyc_data[31:0] ^ data_val) & ~data_mask) == 32'h00000000;
    hi_ok    = ((cyc_data[63:32] ^ data_val) & ~data_mask) == 32'h00000000;
    data_ok  = 1'b1;
    if (HAS_EXTRA && cond[BMC_DATA_EN] && oper_sel) begin // RQ13
      data_ok = !cyc_nodata && lo_ok
              && (cyc_size != BMC_SIZE_QUAD || hi_ok); // RQ15 RQ16
    end
    hit = cyc_valid && cond[BMC_CHAN_EN] && cyc_ok && dir_ok && size_ok
        && bus_ok && asid_ok && flag_ok && data_ok; // RQ12 RQ25
  end
endmodule
`default_nettype wire

//--- core/bmc_pkg.sv
package bmc_pkg;
  localparam logic [31:0] BMC_CH0_COND_ADDR   = 32'hff200000;
  localparam logic [31:0] BMC_CH0_ACTION_ADDR = 32'hff200004;
  localparam logic [31:0] BMC_CH1_COND_ADDR   = 32'hff200020;
  localparam logic [31:0] BMC_CH1_ACTION_ADDR = 32'hff200024;
  localparam logic [31:0] BMC_CH1_DATA_ADDR   = 32'hff200030;
  localparam logic [31:0] BMC_CH1_DMASK_ADDR  = 32'hff200034;
  localparam logic [31:0] BMC_HIT_COUNT_ADDR  = 32'hff200038;
  localparam logic [31:0] BMC_FLAG_ADDR       = 32'hff200600;

  localparam logic [31:0] BMC_COND_RESET   = 32'h20000000;
  localparam logic [31:0] BMC_ACTION_RESET = 32'h00002000;
  localparam logic [31:0] BMC_COND0_MASK   = 32'hffff70f7;
  localparam logic [31:0] BMC_COND1_MASK   = 32'hfffff8f7;
  localparam logic [31:0] BMC_ACTION_MASK  = 32'h00000003;
  localparam logic [31:0] BMC_ACTION_ONES  = 32'h00002000;
  localparam logic [11:0] BMC_COUNT_RESET  = 12'h000;
  localparam logic [11:0] BMC_COUNT_LAST   = 12'h001;

  localparam int BMC_FLAG_EN    = 31;
  localparam int BMC_ASID_EN    = 30;
  localparam int BMC_FSEL_HI    = 29;
  localparam int BMC_FSEL_LO    = 24;
  localparam int BMC_ASID_HI    = 23;
  localparam int BMC_ASID_LO    = 16;
  localparam int BMC_DATA_EN    = 15;
  localparam int BMC_SIZE_HI    = 14;
  localparam int BMC_SIZE_LO    = 12;
  localparam int BMC_COUNT_EN   = 11;
  localparam int BMC_BUS_HI     = 7;
  localparam int BMC_BUS_LO     = 6;
  localparam int BMC_CYC_HI     = 5;
  localparam int BMC_CYC_LO     = 4;
  localparam int BMC_DIR_HI     = 2;
  localparam int BMC_DIR_LO     = 1;
  localparam int BMC_CHAN_EN    = 0;
  localparam int BMC_TIMING_BIT = 1;
  localparam int BMC_BREAK_BIT  = 0;

  localparam logic [5:0] BMC_FSEL_CH0 = 6'h00;
  localparam logic [5:0] BMC_FSEL_CH1 = 6'h01;
  localparam logic [1:0] BMC_CYC_FETCH = 2'h1;
  localparam logic [1:0] BMC_CYC_OPER  = 2'h2;
  localparam logic [1:0] BMC_DIR_READ  = 2'h1;
  localparam logic [1:0] BMC_DIR_WRITE = 2'h2;
  localparam logic [1:0] BMC_BUS_OPER  = 2'h0;
  localparam logic [2:0] BMC_SZ_ANY    = 3'h0;

  typedef enum logic [2:0] {
    BMC_SIZE_ANY,
    BMC_SIZE_BYTE,
    BMC_SIZE_WORD,
    BMC_SIZE_LONG,
    BMC_SIZE_QUAD
  } bmc_size_t;

  typedef enum logic [1:0] {
    BMC_OP_NORMAL,
    BMC_OP_INVALIDATE,
    BMC_OP_PREFETCH,
    BMC_OP_WRITEBACK
  } bmc_op_t;
endpackage

//--- core/bmc_top.sv
// Summary of operation
// RQ1 - Enabled flag condition needs selected flag set.
// RQ2 - Enabled ID compare needs equal ID.
// RQ3 - Flag select picks channel 0 or 1 flag.
// RQ4 - Software sets legal flag select before enabling.
// RQ5 - Channel 0 blocked by its own clear flag.
// RQ6 - Channel 1 blocked by its own clear flag.
// RQ7 - Size field: any, byte, word, long, quad.
// RQ8 - Operand settings apply only to operand cycles.
// RQ9 - Bus select accepts only operand bus code.
// RQ10 - Cycle type selects fetch, operand or either.
// RQ11 - Direction selects read, write or either.
// RQ12 - Disabled channel never hits.
// RQ13 - Channel 1 data compare when enabled.
// RQ14 - Software sets specific size for data compare.
// RQ15 - Quadword compares both data halves.
// RQ16 - Cache ops are longword accesses without data.
// RQ17 - Count compare delays action until count reached.
// RQ18 - Reserved zero bits read zero.
// RQ19 - Action bit 13 reads one; resets 0x2000.
// RQ20 - Action register holds timing and break enable.
// RQ21 - Timing bit: fetch break before or after.
// RQ22 - Break enable gates the break request.
// RQ23 - Flags set on match; writes AND them.
// RQ24 - Count decrements per hit; break at one.
// RQ25 - Hit needs all enabled conditions together.
`timescale 1ns/1ps
`default_nettype none
module bmc_top
  import bmc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  input  wire logic        cyc_valid,
  input  wire logic        cyc_fetch,
  input  wire logic        cyc_write,
  input  wire logic [2:0]  cyc_size,
  input  wire logic [1:0]  cyc_bus,
  input  wire logic [7:0]  cyc_asid,
  input  wire logic [63:0] cyc_data,
  input  wire logic [1:0]  cyc_op,
  output logic             break_req,
  output logic             break_after,
  output logic      [1:0]  break_chan
);
  typedef struct packed {
    logic [1:0]  rst_sync;
    logic [31:0] cond0;
    logic [31:0] cond1;
    logic [1:0]  act0;
    logic [1:0]  act1;
    logic [31:0] data_val;
    logic [31:0] data_mask;
    logic [11:0] count;
    logic [1:0]  flags;
    logic [31:0] rdata;
    logic        brk;
    logic        brk_after;
    logic [1:0]  brk_chan;
  } bmc_state_t;

  bmc_state_t st_d;
  bmc_state_t st_r;
  logic       rst_n;
  logic       hit0;
  logic       hit1;
  logic       sel0;
  logic       sel1;
  logic       nodata;
  logic       eff_size_sel;
  logic [2:0] eff_size;
  logic       act1_ok;
  logic       fire0;
  logic       fire1;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_d;
    end
  end

  assign rst_n = st_r.rst_sync[1];

  // Cache maintenance ops look like longword accesses with no data phase.
  assign nodata = cyc_op != BMC_OP_NORMAL; // RQ16
  assign eff_size_sel = nodata;
  assign eff_size = eff_size_sel ? BMC_SIZE_LONG : cyc_size; // RQ16

  // Flag select codes other than the two legal ones match nothing.
  assign sel0 = st_r.cond0[BMC_FSEL_LO] ? st_r.flags[1] : st_r.flags[0]; // RQ3
  assign sel1 = st_r.cond1[BMC_FSEL_LO] ? st_r.flags[1] : st_r.flags[0]; // RQ3

  bmc_chan #(
    .HAS_EXTRA (1'b0)
  ) u_chan0 (
    .cond       (st_r.cond0),
    .sel_flag   (sel0),
    .cyc_valid  (cyc_valid),
    .cyc_fetch  (cyc_fetch),
    .cyc_write  (cyc_write),
    .cyc_size   (eff_size),
    .cyc_bus    (cyc_bus),
    .cyc_asid   (cyc_asid),
    .cyc_data   (cyc_data),
    .cyc_nodata (nodata),
    .data_val   (st_r.data_val),
    .data_mask  (st_r.data_mask),
    .hit        (hit0)
  );

  bmc_chan #(
    .HAS_EXTRA (1'b1)
  ) u_chan1 (
    .cond       (st_r.cond1),
    .sel_flag   (sel1),
    .cyc_valid  (cyc_valid),
    .cyc_fetch  (cyc_fetch),
    .cyc_write  (cyc_write),
    .cyc_size   (eff_size),
    .cyc_bus    (cyc_bus),
    .cyc_asid   (cyc_asid),
    .cyc_data   (cyc_data),
    .cyc_nodata (nodata),
    .data_val   (st_r.data_val),
    .data_mask  (st_r.data_mask),
    .hit        (hit1)
  );

  // Count compare: only the hit that finds the count at one completes.
  assign act1_ok = !st_r.cond1[BMC_COUNT_EN]
                 || st_r.count == BMC_COUNT_LAST; // RQ17 RQ24
  assign fire0 = hit0;
  assign fire1 = hit1 && act1_ok; // RQ17

  always_comb begin
    st_d = st_r;
    st_d.rst_sync = {st_r.rst_sync[0], 1'b1};
    st_d.brk = 1'b0;
    st_d.brk_chan = 2'h0;
    st_d.brk_after = 1'b0;
    if (hit1 && st_r.cond1[BMC_COUNT_EN] && st_r.count > BMC_COUNT_LAST) begin
      st_d.count = st_r.count - BMC_COUNT_LAST; // RQ24
    end
    if (reg_wr) begin
      case (reg_addr)
        BMC_CH0_COND_ADDR: begin
          st_d.cond0 = reg_wdata & BMC_COND0_MASK; // RQ18
        end
        BMC_CH1_COND_ADDR: begin
          st_d.cond1 = reg_wdata & BMC_COND1_MASK; // RQ18
        end
        BMC_CH0_ACTION_ADDR: begin
          st_d.act0 = reg_wdata[1:0]; // RQ20
        end
        BMC_CH1_ACTION_ADDR: begin
          st_d.act1 = reg_wdata[1:0]; // RQ20
        end
        BMC_CH1_DATA_ADDR: begin
          st_d.data_val = reg_wdata;
        end
        BMC_CH1_DMASK_ADDR: begin
          st_d.data_mask = reg_wdata;
        end
        BMC_HIT_COUNT_ADDR: begin
          st_d.count = reg_wdata[11:0];
        end
        BMC_FLAG_ADDR: begin
          st_d.flags = st_r.flags & reg_wdata[1:0]; // RQ23
        end
        default: begin
        end
      endcase
    end
    // Hardware set wins over a clearing write in the same cycle.
    if (fire0) begin
      st_d.flags[0] = 1'b1; // RQ23
    end
    if (fire1) begin
      st_d.flags[1] = 1'b1; // RQ23
    end
    if (fire1 && st_r.act1[BMC_BREAK_BIT]) begin
      st_d.brk = 1'b1; // RQ22
      st_d.brk_chan[1] = 1'b1;
      st_d.brk_after = cyc_fetch && st_r.act1[BMC_TIMING_BIT]; // RQ21
    end
    if (fire0 && st_r.act0[BMC_BREAK_BIT]) begin
      st_d.brk = 1'b1; // RQ22
      st_d.brk_chan[0] = 1'b1;
      st_d.brk_after = st_d.brk_after
                     || (cyc_fetch && st_r.act0[BMC_TIMING_BIT]); // RQ21
    end
    st_d.rdata = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        BMC_CH0_COND_ADDR: begin
          st_d.rdata = st_r.cond0;
        end
        BMC_CH1_COND_ADDR: begin
          st_d.rdata = st_r.cond1;
        end
        BMC_CH0_ACTION_ADDR: begin
          st_d.rdata = BMC_ACTION_ONES | {30'h0, st_r.act0}; // RQ19
        end
        BMC_CH1_ACTION_ADDR: begin
          st_d.rdata = BMC_ACTION_ONES | {30'h0, st_r.act1}; // RQ19
        end
        BMC_CH1_DATA_ADDR: begin
          st_d.rdata = st_r.data_val;
        end
        BMC_CH1_DMASK_ADDR: begin
          st_d.rdata = st_r.data_mask;
        end
        BMC_HIT_COUNT_ADDR: begin
          st_d.rdata = {20'h0, st_r.count}; // RQ18
        end
        BMC_FLAG_ADDR: begin
          st_d.rdata = {30'h0, st_r.flags}; // RQ18
        end
        default: begin
          st_d.rdata = 32'h00000000;
        end
      endcase
    end
    // Logic state returns to its reset values while the synced reset is low.
    if (!rst_n) begin
      st_d.cond0     = BMC_COND_RESET;
      st_d.cond1     = BMC_COND_RESET;
      st_d.act0      = BMC_ACTION_RESET[1:0];
      st_d.act1      = BMC_ACTION_RESET[1:0];
      st_d.data_val  = 32'h00000000;
      st_d.data_mask = 32'h00000000;
      st_d.count     = BMC_COUNT_RESET;
      st_d.flags     = 2'h0;
      st_d.rdata     = 32'h00000000;
      st_d.brk       = 1'b0;
      st_d.brk_after = 1'b0;
      st_d.brk_chan  = 2'h0;
    end
  end

  assign reg_rdata   = st_r.rdata;
  assign break_req   = st_r.brk;
  assign break_after = st_r.brk_after;
  assign break_chan  = st_r.brk_chan;

  a_disabled_no_flag: assert property ( // RQ12
    @(posedge clk_sys) disable iff (!rst_n)
    !st_r.cond0[BMC_CHAN_EN] && !reg_wr |=> $stable(st_r.flags[0]))
    else $error("Disabled channel 0 set its flag.");
  a_disabled_no_hit1: assert property ( // RQ12
    @(posedge clk_sys) disable iff (!rst_n)
    !st_r.cond1[BMC_CHAN_EN] |-> !hit1)
    else $error("Disabled channel 1 reported a hit.");
  a_own_flag_block0: assert property ( // RQ5
    @(posedge clk_sys) disable iff (!rst_n)
    st_r.cond0[BMC_FLAG_EN] && st_r.cond0[29:24] == BMC_FSEL_CH0
    && !st_r.flags[0] |-> !hit0)
    else $error("Channel 0 hit with its own flag clear.");
  a_own_flag_block1: assert property ( // RQ6
    @(posedge clk_sys) disable iff (!rst_n)
    st_r.cond1[BMC_FLAG_EN] && st_r.cond1[29:24] == BMC_FSEL_CH1
    && !st_r.flags[1] |-> !hit1)
    else $error("Channel 1 hit with its own flag clear.");
  a_bad_fsel_nohit: assert property ( // RQ3
    @(posedge clk_sys) disable iff (!rst_n)
    st_r.cond1[BMC_FLAG_EN] && st_r.cond1[29:24] == BMC_COND_RESET[29:24]
    |-> !hit1)
    else $error("Reserved flag select allowed a hit.");
  a_break_gated: assert property ( // RQ22
    @(posedge clk_sys) disable iff (!rst_n)
    break_req |-> $past(fire0) && $past(st_r.act0[0])
    || $past(fire1) && $past(st_r.act1[0]))
    else $error("Break without an enabled matching channel.");
  a_flag_set_hit: assert property ( // RQ23
    @(posedge clk_sys) disable iff (!rst_n)
    fire1 |=> st_r.flags[1])
    else $error("Channel 1 flag not set after match.");
  a_flag_set_hit0: assert property ( // RQ23
    @(posedge clk_sys) disable iff (!rst_n)
    fire0 |=> st_r.flags[0])
    else $error("Channel 0 flag not set after match.");
  a_count_decr: assert property ( // RQ24
    @(posedge clk_sys) disable iff (!rst_n)
    hit1 && st_r.cond1[BMC_COUNT_EN] && st_r.count > 12'h001 && !reg_wr
    |=> st_r.count == $past(st_r.count) - 12'h001
    && st_r.flags[1] == $past(st_r.flags[1]))
    else $error("Hit count did not step down by one.");
  a_count_gate: assert property ( // RQ17
    @(posedge clk_sys) disable iff (!rst_n)
    hit1 && st_r.cond1[BMC_COUNT_EN] && st_r.count != BMC_COUNT_LAST
    |=> !break_chan[1])
    else $error("Channel 1 acted before its count was reached.");
  a_action_bit13: assert property ( // RQ19
    @(posedge clk_sys) disable iff (!rst_n)
    reg_rd && reg_addr == BMC_CH0_ACTION_ADDR
    |=> reg_rdata[13] && reg_rdata[31:14] == 18'h0)
    else $error("Action register read wrong fixed bits.");
  a_after_fetch_only: assert property ( // RQ21
    @(posedge clk_sys) disable iff (!rst_n)
    break_after |-> break_req && $past(cyc_fetch))
    else $error("After-execution timing on a non-fetch break.");
  a_asid_mismatch: assert property ( // RQ2
    @(posedge clk_sys) disable iff (!rst_n)
    st_r.cond0[BMC_ASID_EN] && st_r.cond0[23:16] != cyc_asid |-> !hit0)
    else $error("Channel 0 hit with wrong ID.");
  // A cache operation carries no data, so a data condition can never hold.
  a_data_nodata: assert property ( // RQ16
    @(posedge clk_sys) disable iff (!rst_n)
    st_r.cond1[BMC_DATA_EN] && nodata && !cyc_fetch |-> !hit1)
    else $error("Data compare matched a cache operation.");
endmodule
`default_nettype wire

//--- sim/bmc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module bmc_core_model
  import bmc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rq,
  input  wire logic        f,
  input  wire logic        w,
  input  wire logic [2:0]  sz,
  input  wire logic [1:0]  bs,
  input  wire logic [7:0]  as,
  input  wire logic [63:0] dt,
  input  wire logic [1:0]  op,
  output logic             cyc_valid,
  output logic             cyc_fetch,
  output logic             cyc_write,
  output logic      [2:0]  cyc_size,
  output logic      [1:0]  cyc_bus,
  output logic      [7:0]  cyc_asid,
  output logic      [63:0] cyc_data,
  output logic      [1:0]  cyc_op
);
  logic [63:0] last_q = 64'h0;
  always_ff @(posedge clk_sys) begin
    if (rq) begin
      last_q <= dt;
    end
  end
  // Idle data lines float, so the last value must not linger on them.
  assign cyc_data = rq ? dt : ~last_q;
  assign cyc_asid = rq ? as : ~as;
  assign cyc_valid = rq;
  assign cyc_fetch = f;
  assign cyc_bus = bs;
  assign cyc_op = op;
  // Cache operations are presented as longword accesses.
  assign cyc_size = (op != 2'h0) ? 3'h3 : sz;
  assign cyc_write = (op == 2'h1) | ((op == 2'h0) & w);
endmodule
`default_nettype wire

//--- sim/tb_breakpoint_match_conditions.sv
`timescale 1ns/1ps
`default_nettype none
module tb_breakpoint_match_conditions
  import bmc_pkg::*;
();
  localparam logic [31:0] C0 = BMC_CH0_COND_ADDR;
  localparam logic [31:0] C1 = BMC_CH1_COND_ADDR;
  localparam logic [31:0] A0 = BMC_CH0_ACTION_ADDR;
  localparam logic [31:0] A1 = BMC_CH1_ACTION_ADDR;
  localparam logic [31:0] FL = BMC_FLAG_ADDR;
  localparam logic [31:0] HC = BMC_HIT_COUNT_ADDR;
  logic        clk_sys, nrst, reg_wr, reg_rd, rq, f, w;
  logic        break_req, break_after, cyc_valid, cyc_fetch, cyc_write;
  logic [31:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0]  sz, cyc_size;
  logic [1:0]  bs, op, break_chan, cyc_bus, cyc_op;
  logic [7:0]  as, cyc_asid;
  logic [63:0] dt, cyc_data;
  int          n_errors, compares, i, j;

  bmc_core_model bmc_core_model_i (.clk_sys, .rq, .f, .w, .sz, .bs, .as,
    .dt, .op, .cyc_valid, .cyc_fetch, .cyc_write, .cyc_size, .cyc_bus,
    .cyc_asid, .cyc_data, .cyc_op);
  bmc_top bmc_top_i (.clk_sys, .nrst, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .cyc_valid, .cyc_fetch, .cyc_write, .cyc_size,
    .cyc_bus, .cyc_asid, .cyc_data, .cyc_op, .break_req, .break_after,
    .break_chan);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task chk(input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task print_verdict;
    if (n_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Strobes drop for a cycle between accesses, so no signal is set twice.
  task wr(input logic [31:0] a, d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask

  task rd(input logic [31:0] a, e);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk(reg_rdata, e);
  endtask

  task cy(input logic fi, wi, input logic [2:0] si, input logic [63:0] di,
          input logic [1:0] ec, input logic ea);
    @(negedge clk_sys);
    rq = 1'b1;
    f = fi;
    w = wi;
    sz = si;
    dt = di;
    @(negedge clk_sys);
    rq = 1'b0;
    chk({break_req, break_after & break_req, break_chan},
        {|ec, ea, ec});
  endtask

  // Flag select is left at channel 0; a reserved code is enabled only where a test ORs in 32'ha0000000.
  function automatic logic [31:0] cw(input int c, d, s);
    return 32'h1 | 32'(c << 4) | 32'(d << 1) | 32'(s << 12);
  endfunction

  initial begin
    #1000000;
    n_errors++;
    $display("wrong value at %0t: run timed out", $time);
    print_verdict;
  end

  initial begin
    {nrst, reg_wr, reg_rd, rq, f, w} = 6'h0;
    {reg_addr, reg_wdata, sz, bs, op, as, dt} = '0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    nrst = 1'b1;
    repeat (3) @(negedge clk_sys);
    rd(C0, 32'h20000000);
    rd(C1, 32'h20000000);
    rd(A0, 32'h00002000);
    rd(A1, 32'h00002000);
    rd(FL, 32'h0);
    wr(C0, '1);
    rd(C0, 32'hffff70f7);
    wr(C1, '1);
    rd(C1, 32'hfffff8f7);
    wr(A0, '1);
    rd(A0, 32'h00002003);
    wr(A0, 32'h0);
    rd(A0, 32'h00002000);
    wr(HC, '1);
    rd(HC, 32'h00000fff);
    rd(32'hff200040, 32'h0);
    wr(C1, 32'h0);
    wr(A0, 32'h2001);
    for (i = 0; i < 4; i++) begin
      wr(C0, cw(i, 0, 0));
      for (j = 0; j < 2; j++)
        cy(j, 0, 3, 0, {1'b0, (i == 1) ? j == 1 : (i == 2) ? j == 0 : 1'b1},
           0);
    end
    for (i = 0; i < 4; i++) begin
      wr(C0, cw(2, i, 0));
      for (j = 0; j < 2; j++)
        cy(0, j, 3, 0, {1'b0, (i == 1) ? j == 0 : (i == 2) ? j == 1 : 1'b1},
           0);
    end
    for (i = 0; i < 6; i++) begin
      wr(C0, cw(2, 0, i));
      for (j = 1; j < 5; j++)
        cy(0, 0, j, 0, {1'b0, i == 0 || i == j}, 0);
    end
    wr(A0, 32'h2003);
    wr(C0, cw(1, 2, 4));
    cy(1, 0, 1, 0, 2'b01, 1);
    wr(C0, cw(0, 0, 0));
    cy(0, 0, 3, 0, 2'b01, 0);
    wr(C0, cw(0, 0, 0) & ~32'h1);
    cy(1, 0, 3, 0, 2'b00, 0);
    cy(0, 1, 3, 0, 2'b00, 0);
    wr(C0, cw(2, 0, 0) | 32'h80);
    cy(0, 0, 3, 0, 2'b00, 0);
    wr(C0, cw(2, 0, 0));
    bs = 2'h1;
    cy(0, 0, 3, 0, 2'b00, 0);
    bs = 2'h0;
    wr(C0, cw(0, 0, 0) | 32'h405a0000);
    as = 8'h5a;
    cy(0, 0, 3, 0, 2'b01, 0);
    as = 8'h5b;
    cy(0, 0, 3, 0, 2'b00, 0);
    as = 8'h00;
    wr(FL, 32'h0);
    wr(A0, 32'h2000);
    wr(C0, cw(0, 0, 0));
    cy(0, 0, 3, 0, 2'b00, 0);
    rd(FL, 32'h1);
    wr(FL, 32'h2);
    rd(FL, 32'h0);
    wr(A0, 32'h2001);
    wr(A1, 32'h2001);
    wr(C0, cw(0, 0, 0) | 32'h81000000);
    wr(C1, cw(0, 0, 0));
    cy(0, 0, 3, 0, 2'b10, 0);
    cy(0, 0, 3, 0, 2'b11, 0);
    rd(FL, 32'h3);
    wr(FL, 32'h2);
    rd(FL, 32'h2);
    wr(C0, cw(0, 0, 0) | 32'h80000000);
    cy(0, 0, 3, 0, 2'b10, 0);
    wr(C0, 32'h0);
    wr(FL, 32'h0);
    wr(C1, cw(0, 0, 0) | 32'h81000000);
    cy(0, 0, 3, 0, 2'b00, 0);
    wr(C1, cw(0, 0, 0) | 32'ha0000000);
    wr(C0, cw(0, 0, 0));
    cy(0, 0, 3, 0, 2'b01, 0);
    cy(0, 0, 3, 0, 2'b01, 0);
    wr(C0, 32'h0);
    wr(BMC_CH1_DATA_ADDR, 32'h12345678);
    wr(BMC_CH1_DMASK_ADDR, 32'h0000000f);
    wr(C1, cw(2, 0, 3) | 32'h8000);
    cy(0, 0, 3, 64'h12345670, 2'b10, 0);
    cy(0, 0, 3, 64'h12345778, 2'b00, 0);
    wr(C1, cw(2, 0, 3));
    cy(0, 0, 3, 64'h0, 2'b10, 0);
    wr(C1, cw(2, 0, 4) | 32'h8000);
    cy(0, 0, 4, 64'h1234567a12345675, 2'b10, 0);
    cy(0, 0, 4, 64'h1334567a12345675, 2'b00, 0);
    wr(C1, cw(2, 2, 3));
    op = 2'h1;
    cy(0, 0, 1, 0, 2'b10, 0);
    op = 2'h2;
    cy(0, 1, 1, 0, 2'b00, 0);
    wr(C1, cw(2, 1, 3));
    op = 2'h3;
    cy(0, 1, 1, 0, 2'b10, 0);
    op = 2'h1;
    wr(C1, cw(2, 2, 3) | 32'h8000);
    cy(0, 0, 1, 64'h12345678, 2'b00, 0);
    op = 2'h0;
    wr(C1, cw(0, 0, 0) | 32'h800);
    wr(HC, 32'h3);
    cy(0, 0, 3, 0, 2'b00, 0);
    cy(0, 0, 3, 0, 2'b00, 0);
    cy(0, 0, 3, 0, 2'b10, 0);
    cy(0, 0, 3, 0, 2'b10, 0);
    rd(HC, 32'h1);
    print_verdict;
  end
endmodule
`default_nettype wire
